// >>> verilog/tidc_regs.svh
`ifndef TIDC_REGS_SVH
`define TIDC_REGS_SVH
`define TIDC_IR_W      4
`define TIDC_IR_EXTEST 4'h0
`define TIDC_IR_INTEST 4'h1
`define TIDC_IR_SAMPLE 4'h2
`define TIDC_IR_ABORT  4'h8
`define TIDC_IR_DPA    4'hA
`define TIDC_IR_APA    4'hB
`define TIDC_IR_IDENT  4'hE
`define TIDC_IR_BYP    4'hF
`define TIDC_IR_CAPT   4'h1
`define TIDC_ID_W      32
`define TIDC_ID_LSB    1'h1
`define TIDC_BYP_CAP   1'h0
`define TIDC_DAU_W     35
`define TIDC_HDR_W     3
`define TIDC_ACK_WAIT  3'h1
`define TIDC_ABT_LSB   3
`define TIDC_ABT_W     5
`define TIDC_GPIO_N    8
`define TIDC_BSR_W     25
`endif

// >>> verilog/tidc_pkg.sv
`default_nettype none
package tidc_pkg;
`include "tidc_regs.svh"
   typedef enum logic [2:0] {
      sel_ident, sel_byp, sel_bsr, sel_abort, sel_dpa, sel_apa
   } tidc_sel_t;
   typedef enum logic {kind_dp, kind_ap} tidc_kind_t;
   typedef struct packed {
      logic [`TIDC_IR_W-1:0]  ir_sh;
      logic [`TIDC_IR_W-1:0]  ir;
      logic [`TIDC_DAU_W-1:0] dr;
      logic                   tdo;
      logic                   tdo_oe;
      logic                   req_tgl;
      tidc_kind_t             req_kind;
      logic [`TIDC_DAU_W-1:0] req_data;
      logic                   abt_tgl;
      logic [`TIDC_ABT_W-1:0] abt_data;
      logic                   ack_s1;
      logic                   ack_s2;
      logic                   ack_seen;
      logic [`TIDC_DAU_W-1:0] resp;
   } tidc_tap_t;
   typedef struct packed {
      logic [`TIDC_GPIO_N:0]   in_s1;
      logic [`TIDC_GPIO_N:0]   in_s2;
      logic [`TIDC_BSR_W-1:0]  sh;
      logic [`TIDC_BSR_W-1:0]  upd;
      logic [`TIDC_GPIO_N-1:0] pad_out;
      logic [`TIDC_GPIO_N-1:0] pad_oe;
      logic [`TIDC_GPIO_N-1:0] core_in;
   } tidc_bsr_t;
   typedef struct packed {
      logic rq_s1, rq_s2, rq_seen, busy, req;
      tidc_kind_t kind;
      logic [`TIDC_DAU_W-1:0] wdata;
      logic ack;
      logic [`TIDC_DAU_W-1:0] resp;
      logic ab_s1, ab_s2, ab_seen, abort;
      logic [`TIDC_ABT_W-2:0] clr;
   } tidc_xfr_t;
endpackage
`default_nettype wire

// >>> verilog/tidc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "tidc_regs.svh"
interface tidc_link_if;
   import tidc_pkg::*;
   logic cap, shf, upd, tdi, sel_bsr, ext_mode, int_mode, bsr_nxt;
   logic                   req_tgl;
   tidc_kind_t             req_kind;
   logic [`TIDC_DAU_W-1:0] req_data;
   logic                   abt_tgl;
   logic [`TIDC_ABT_W-1:0] abt_data;
   logic                   ack_tgl;
   logic [`TIDC_DAU_W-1:0] resp;
   modport tap (output cap, shf, upd, tdi, sel_bsr, ext_mode, int_mode,
                output req_tgl, req_kind, req_data, abt_tgl, abt_data,
                input bsr_nxt, ack_tgl, resp);
   modport bsr (input cap, shf, upd, tdi, sel_bsr, ext_mode, int_mode,
                output bsr_nxt);
   modport xfr (input req_tgl, req_kind, req_data, abt_tgl, abt_data,
                output ack_tgl, resp);
endinterface
`default_nettype wire

// >>> verilog/tidc_bsr.sv
`timescale 1ns/1ps
`default_nettype none
`include "tidc_regs.svh"
module tidc_bsr (
   input  wire logic                    tck,
   input  wire logic                    rst,
   tidc_link_if.bsr                     link,
   input  wire logic [`TIDC_GPIO_N-1:0] pad_in,
   input  wire logic                    rst_pin,
   input  wire logic [`TIDC_GPIO_N-1:0] core_out,
   input  wire logic [`TIDC_GPIO_N-1:0] core_oe,
   output logic      [`TIDC_GPIO_N-1:0] pad_out,
   output logic      [`TIDC_GPIO_N-1:0] pad_oe,
   output logic      [`TIDC_GPIO_N-1:0] core_in
);
   import tidc_pkg::*;
   tidc_bsr_t c, n;
   logic [`TIDC_BSR_W-1:0]  cap_v;
   logic [`TIDC_GPIO_N-1:0] po_d, oe_d, ci_d;
   // Per pin: input, output, enable; reset pin input cell last
   for (genvar g = 0; g < `TIDC_GPIO_N; g++) begin : g_cell
      assign cap_v[3*g]   = c.in_s2[g]; // RQ15
      assign cap_v[3*g+1] = c.pad_out[g];
      assign cap_v[3*g+2] = c.pad_oe[g];
      assign po_d[g] = link.ext_mode ? c.upd[3*g+1] : core_out[g]; // RQ19
      assign oe_d[g] = link.ext_mode ? c.upd[3*g+2] : core_oe[g];
      assign ci_d[g] = link.int_mode ? c.upd[3*g] : c.in_s2[g]; // RQ19
   end
   assign cap_v[`TIDC_BSR_W-1] = c.in_s2[`TIDC_GPIO_N]; // RQ16
   assign link.bsr_nxt = n.sh[0];
   always_comb begin
      n = c;
      n.in_s1 = {rst_pin, pad_in};
      n.in_s2 = c.in_s1;
      if (link.cap && link.sel_bsr) begin
         n.sh = cap_v; // RQ17
      end else if (link.shf && link.sel_bsr) begin
         n.sh = {link.tdi, c.sh[`TIDC_BSR_W-1:1]}; // RQ18
      end
      if (link.upd && link.sel_bsr) begin
         n.upd = c.sh;
      end
      n.pad_out = po_d;
      n.pad_oe  = oe_d;
      n.core_in = ci_d;
      if (rst) begin
         n.sh      = '0;
         n.upd     = '0;
         n.pad_out = '0;
         n.pad_oe  = '0;
         n.core_in = '0;
      end
   end
   always_ff @(posedge tck) begin
      c <= n;
   end
   assign pad_out = c.pad_out;
   assign pad_oe  = c.pad_oe;
   assign core_in = c.core_in;
   property p_rst_cell;
      @(posedge tck) disable iff (rst)
      link.cap && link.sel_bsr |=>
         c.sh[`TIDC_BSR_W-1] == $past(c.in_s2[`TIDC_GPIO_N]);
   endproperty
   a_rst_cell: assert property (p_rst_cell) // RQ16
      else $error("reset pin cell not captured");
   property p_ext_drive;
      @(posedge tck) disable iff (rst)
      link.ext_mode ##1 link.ext_mode |=> c.pad_out[0] == $past(c.upd[1]);
   endproperty
   a_ext_drive: assert property (p_ext_drive) // RQ19
      else $error("pad not driven from update cell");
endmodule
`default_nettype wire

// >>> verilog/tidc_xfer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tidc_regs.svh"
module tidc_xfer (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   tidc_link_if.xfr                    link,
   input  wire logic                   dau_done,
   input  wire logic [`TIDC_HDR_W-1:0] dau_ack,
   input  wire logic [`TIDC_ID_W-1:0]  dau_rdata,
   output logic                        dau_req,
   output tidc_pkg::tidc_kind_t        dau_kind,
   output logic      [`TIDC_DAU_W-1:0] dau_wdata,
   output logic                        dau_abort,
   output logic      [`TIDC_ABT_W-2:0] dau_clr
);
   import tidc_pkg::*;
   tidc_xfr_t c, n;
   always_comb begin
      n = c;
      n.req   = 1'b0;
      n.abort = 1'b0;
      n.clr   = '0;
      n.rq_s1 = link.req_tgl;
      n.rq_s2 = c.rq_s1;
      n.ab_s1 = link.abt_tgl;
      n.ab_s2 = c.ab_s1;
      if (!rst_n) begin
         // Resync to the far side so a lone reset fakes no request
         n.rq_seen = c.rq_s2;
         n.ack     = c.rq_s2;
         n.ab_seen = c.ab_s2;
         n.busy    = 1'b0;
         n.kind    = kind_dp;
         n.wdata   = '0;
         n.resp    = '0;
      end else begin
         if (c.rq_s2 != c.rq_seen && !c.busy) begin
            n.rq_seen = c.rq_s2;
            n.req     = 1'b1;
            n.busy    = 1'b1;
            n.kind    = link.req_kind;
            n.wdata   = link.req_data;
         end
         if (c.busy && dau_done) begin
            n.busy = 1'b0;
            n.resp = {dau_rdata, dau_ack};
            n.ack  = c.rq_seen;
         end
         if (c.ab_s2 != c.ab_seen) begin
            n.ab_seen = c.ab_s2;
            n.abort   = link.abt_data[0]; // RQ4
            n.clr     = link.abt_data[`TIDC_ABT_W-1:1];
         end
      end
   end
   always_ff @(posedge clk) begin
      c <= n;
   end
   assign link.ack_tgl = c.ack;
   assign link.resp    = c.resp;
   assign dau_req      = c.req;
   assign dau_kind     = c.kind;
   assign dau_wdata    = c.wdata;
   assign dau_abort    = c.abort;
   assign dau_clr      = c.clr;
   property p_abort_fwd;
      @(posedge clk) disable iff (!rst_n)
      c.ab_s2 != c.ab_seen |=> dau_abort == $past(link.abt_data[0]);
   endproperty
   a_abort_fwd: assert property (p_abort_fwd) // RQ4
      else $error("abort not forwarded");
endmodule
`default_nettype wire

// >>> verilog/tidc_chains.sv
// Notes on behaviour
// RQ1: Four-bit instruction; 1000 abort, 1010 dp, 1011 ap, 1110 ident, 1111 bypass.
// RQ2: Every unassigned instruction code acts as bypass.
// RQ3: Abort instruction puts the abort chain alone between tdi and tdo.
// RQ4: Updated abort data clears error flags or cancels a pending access.
// RQ5: Debug-port instruction connects its chain, reaching debug and status registers.
// RQ6: Access-port instruction connects its chain, reaching internal buses.
// RQ7: Identification loaded on power-on reset, trst and test-logic-reset.
// RQ8: Identification chain is 32 bits, selected by the identification code.
// RQ9: Identification bit zero always reads one.
// RQ10: Identification captures a fixed 32-bit constant naming the core.
// RQ11: Bypass is one stage between tdi and tdo.
// RQ12: Bypass stage captures zero.
// RQ13: Exactly six chains: ident, bypass, boundary, ap, dp, abort.
// RQ14: Boundary chain covers every general pin in package order.
// RQ15: Each pin has input, output, enable cells, in that order.
// RQ16: Reset pin has one input cell only.
// RQ17: Sample/preload captures all pad values in Capture-DR.
// RQ18: Shift-DR sends captured bits out while preload bits come in.
// RQ19: Extest drives preloaded values to pads; intest drives them inward.
// RQ20: Abort, dp and ap chains are each 35 bits.
// RQ21: One bit per rising tck in Shift-DR, least significant first.
`timescale 1ns/1ps
`default_nettype none
`include "tidc_regs.svh"
module tidc_chains #(
   parameter logic [31:0] ID_VALUE = 32'h0A5C_3001 // Arbitrary value
) (
   input  wire logic                    tck,
   input  wire logic                    por_n,
   input  wire logic                    trst_n,
   input  wire logic                    tap_tlr,
   input  wire logic                    tap_capture_ir,
   input  wire logic                    tap_shift_ir,
   input  wire logic                    tap_update_ir,
   input  wire logic                    tap_capture_dr,
   input  wire logic                    tap_shift_dr,
   input  wire logic                    tap_update_dr,
   input  wire logic                    tdi,
   output logic                         tdo,
   output logic                         tdo_oe,
   input  wire logic [`TIDC_GPIO_N-1:0] pad_in,
   input  wire logic                    rst_pin,
   input  wire logic [`TIDC_GPIO_N-1:0] core_out,
   input  wire logic [`TIDC_GPIO_N-1:0] core_oe,
   output logic      [`TIDC_GPIO_N-1:0] pad_out,
   output logic      [`TIDC_GPIO_N-1:0] pad_oe,
   output logic      [`TIDC_GPIO_N-1:0] core_in,
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    dau_done,
   input  wire logic [`TIDC_HDR_W-1:0]  dau_ack,
   input  wire logic [`TIDC_ID_W-1:0]   dau_rdata,
   output logic                         dau_req,
   output tidc_pkg::tidc_kind_t         dau_kind,
   output logic      [`TIDC_DAU_W-1:0]  dau_wdata,
   output logic                         dau_abort,
   output logic      [`TIDC_ABT_W-2:0]  dau_clr
);
   import tidc_pkg::*;

   tidc_link_if link ();

   tidc_tap_t c, n;
   tidc_sel_t sel;
   logic      tck_rst;
   logic      pending;

   // Unknown codes fall to bypass so tdi always reaches tdo
   function automatic tidc_sel_t decode(input logic [`TIDC_IR_W-1:0] ir);
      case (ir) // RQ1
         `TIDC_IR_EXTEST, `TIDC_IR_INTEST, `TIDC_IR_SAMPLE:
            decode = sel_bsr;
         `TIDC_IR_ABORT: decode = sel_abort;
         `TIDC_IR_DPA:   decode = sel_dpa;
         `TIDC_IR_APA:   decode = sel_apa;
         `TIDC_IR_IDENT: decode = sel_ident;
         default:        decode = sel_byp; // RQ2
      endcase
   endfunction

   // Synchronous to tck; trst and the reset state need running tck
   assign tck_rst = !por_n || !trst_n || tap_tlr;
   assign sel     = decode(c.ir);
   // No new access while the last one is still in flight
   assign pending = c.req_tgl != c.ack_seen;

   assign link.cap      = tap_capture_dr;
   assign link.shf      = tap_shift_dr;
   assign link.upd      = tap_update_dr;
   assign link.tdi      = tdi;
   assign link.sel_bsr  = sel == sel_bsr;
   assign link.ext_mode = c.ir == `TIDC_IR_EXTEST;
   assign link.int_mode = c.ir == `TIDC_IR_INTEST;
   assign link.req_tgl  = c.req_tgl;
   assign link.req_kind = c.req_kind;
   assign link.req_data = c.req_data;
   assign link.abt_tgl  = c.abt_tgl;
   assign link.abt_data = c.abt_data;

   always_comb begin
      n = c;
      n.ack_s1 = link.ack_tgl;
      n.ack_s2 = c.ack_s1;
      // Tracks every cycle so an unknown after power-up clears
      n.ack_seen = c.ack_s2;
      if (c.ack_s2 != c.ack_seen) begin
         n.resp     = link.resp;
      end

      if (tap_capture_ir) begin
         n.ir_sh = `TIDC_IR_CAPT;
      end else if (tap_shift_ir) begin
         n.ir_sh = {tdi, c.ir_sh[`TIDC_IR_W-1:1]};
      end
      if (tap_update_ir) begin
         n.ir = c.ir_sh;
      end

      if (tap_capture_dr) begin
         case (sel) // RQ13
            sel_ident: begin
               n.dr = {{`TIDC_HDR_W{1'b0}}, ID_VALUE[`TIDC_ID_W-1:1], // RQ10
                       `TIDC_ID_LSB}; // RQ9
            end
            sel_byp: begin
               n.dr[0] = `TIDC_BYP_CAP; // RQ12
            end
            sel_abort: begin
               n.dr = '0;
            end
            sel_dpa, sel_apa: begin
               if (pending) begin
                  n.dr = {{`TIDC_ID_W{1'b0}}, `TIDC_ACK_WAIT};
               end else begin
                  n.dr = c.resp;
               end
            end
            default: begin
               n.dr = c.dr;
            end
         endcase
      end else if (tap_shift_dr) begin
         case (sel)
            sel_ident: begin
               n.dr[`TIDC_ID_W-1:0] = {tdi, c.dr[`TIDC_ID_W-1:1]}; // RQ8
            end
            sel_byp: begin
               n.dr[0] = tdi; // RQ11
            end
            sel_abort, sel_dpa, sel_apa: begin
               n.dr = {tdi, c.dr[`TIDC_DAU_W-1:1]}; // RQ20
            end
            default: begin
               n.dr = c.dr;
            end
         endcase
      end

      if (tap_update_dr) begin
         case (sel)
            sel_abort: begin
               n.abt_tgl  = !c.abt_tgl; // RQ3
               n.abt_data = c.dr[`TIDC_ABT_LSB +: `TIDC_ABT_W]; // RQ4
            end
            sel_dpa: begin
               if (!pending) begin
                  n.req_tgl  = !c.req_tgl; // RQ5
                  n.req_kind = kind_dp;
                  n.req_data = c.dr;
               end
            end
            sel_apa: begin
               if (!pending) begin
                  n.req_tgl  = !c.req_tgl; // RQ6
                  n.req_kind = kind_ap;
                  n.req_data = c.dr;
               end
            end
            default: begin
               n.req_tgl = c.req_tgl;
            end
         endcase
      end

      // Output follows the chain's new bit zero, lsb first
      if (tap_capture_ir || tap_shift_ir) begin
         n.tdo = n.ir_sh[0];
      end else if (tap_capture_dr || tap_shift_dr) begin
         n.tdo = (sel == sel_bsr) ? link.bsr_nxt : n.dr[0]; // RQ21
      end
      n.tdo_oe = tap_capture_ir || tap_shift_ir ||
                 tap_capture_dr || tap_shift_dr;

      if (tck_rst) begin
         n.ir     = `TIDC_IR_IDENT; // RQ7
         n.ir_sh  = `TIDC_IR_CAPT;
         n.tdo    = 1'b0;
         n.tdo_oe = 1'b0;
      end
      if (!por_n) begin
         n.dr       = '0;
         // Constant breaks the reset loop; por and rst_n come together
         n.req_tgl  = 1'b0;
         n.ack_seen = c.ack_s2;
         n.req_kind = kind_dp;
         n.req_data = '0;
         n.abt_tgl  = 1'b0;
         n.abt_data = '0;
         n.resp     = '0;
      end
   end

   always_ff @(posedge tck) begin
      c <= n;
   end

   assign tdo    = c.tdo;
   assign tdo_oe = c.tdo_oe;

   tidc_bsr u_bsr (
      .tck      (tck),
      .rst      (tck_rst),
      .link     (link.bsr),
      .pad_in   (pad_in),
      .rst_pin  (rst_pin),
      .core_out (core_out),
      .core_oe  (core_oe),
      .pad_out  (pad_out),
      .pad_oe   (pad_oe),
      .core_in  (core_in)
   ); // RQ14

   tidc_xfer u_xfer (
      .clk       (clk),
      .rst_n     (rst_n),
      .link      (link.xfr),
      .dau_done  (dau_done),
      .dau_ack   (dau_ack),
      .dau_rdata (dau_rdata),
      .dau_req   (dau_req),
      .dau_kind  (dau_kind),
      .dau_wdata (dau_wdata),
      .dau_abort (dau_abort),
      .dau_clr   (dau_clr)
   );

   property p_tlr_ident;
      @(posedge tck) disable iff (!por_n)
      tap_tlr |=> c.ir == `TIDC_IR_IDENT;
   endproperty
   a_tlr_ident: assert property (p_tlr_ident) // RQ7
      else $error("reset state did not load identification");

   property p_unassigned;
      @(posedge tck) disable iff (tck_rst)
      !(c.ir inside {`TIDC_IR_EXTEST, `TIDC_IR_INTEST, `TIDC_IR_SAMPLE,
        `TIDC_IR_ABORT, `TIDC_IR_DPA, `TIDC_IR_APA, `TIDC_IR_IDENT})
         |-> sel == sel_byp;
   endproperty
   a_unassigned: assert property (p_unassigned) // RQ2
      else $error("unassigned code not bypass");

   property p_id_cap;
      @(posedge tck) disable iff (tck_rst)
      tap_capture_dr && sel == sel_ident |=>
         c.tdo && c.dr[`TIDC_ID_W-1:1] == ID_VALUE[`TIDC_ID_W-1:1];
   endproperty
   a_id_cap: assert property (p_id_cap) // RQ10
      else $error("identification capture wrong");

   property p_byp_cap;
      @(posedge tck) disable iff (tck_rst)
      tap_capture_dr && sel == sel_byp |=> !c.tdo;
   endproperty
   a_byp_cap: assert property (p_byp_cap) // RQ12
      else $error("bypass capture not zero");

   property p_byp_path;
      @(posedge tck) disable iff (tck_rst)
      tap_shift_dr && !tap_capture_dr && sel == sel_byp |=>
         c.tdo == $past(tdi);
   endproperty
   a_byp_path: assert property (p_byp_path) // RQ11
      else $error("bypass not one stage");

   property p_dau_shift;
      @(posedge tck) disable iff (tck_rst)
      tap_shift_dr && !tap_capture_dr && sel inside {sel_abort, sel_dpa}
         |=> c.tdo == $past(c.dr[1]) && c.dr[`TIDC_DAU_W-1] == $past(tdi);
   endproperty
   a_dau_shift: assert property (p_dau_shift) // RQ20
      else $error("35-bit chain shift wrong");

   property p_dp_req;
      @(posedge tck) disable iff (tck_rst)
      tap_update_dr && sel == sel_dpa && !pending |=>
         c.req_tgl != $past(c.req_tgl) && c.req_kind == kind_dp;
   endproperty
   a_dp_req: assert property (p_dp_req) // RQ5
      else $error("dp access not launched");

   property p_ap_req;
      @(posedge tck) disable iff (tck_rst)
      tap_update_dr && sel == sel_apa && !pending |=>
         c.req_tgl != $past(c.req_tgl) && c.req_kind == kind_ap;
   endproperty
   a_ap_req: assert property (p_ap_req) // RQ6
      else $error("ap access not launched");

   property p_abt_upd;
      @(posedge tck) disable iff (tck_rst)
      tap_update_dr && sel == sel_abort |=>
         c.abt_tgl != $past(c.abt_tgl) &&
         c.abt_data == $past(c.dr[`TIDC_ABT_LSB +: `TIDC_ABT_W]);
   endproperty
   a_abt_upd: assert property (p_abt_upd) // RQ4
      else $error("abort not issued");

   property p_tdo_quiet;
      @(posedge tck) disable iff (tck_rst)
      !(tap_capture_ir || tap_shift_ir || tap_capture_dr || tap_shift_dr)
         |=> !c.tdo_oe;
   endproperty
   a_tdo_quiet: assert property (p_tdo_quiet) // RQ21
      else $error("tdo driven outside a scan");

   property p_tdo_drive;
      @(posedge tck) disable iff (tck_rst)
      (tap_capture_dr || tap_shift_dr) |=> c.tdo_oe;
   endproperty
   a_tdo_drive: assert property (p_tdo_drive) // RQ21
      else $error("tdo not driven during a scan");

   property p_ir_load;
      @(posedge tck) disable iff (tck_rst)
      tap_update_ir |=> c.ir == $past(c.ir_sh);
   endproperty
   a_ir_load: assert property (p_ir_load) // RQ1
      else $error("instruction not updated");

   property p_id_shift;
      @(posedge tck) disable iff (tck_rst)
      tap_shift_dr && !tap_capture_dr && sel == sel_ident |=>
         c.tdo == $past(c.dr[1]) && c.dr[`TIDC_ID_W-1] == $past(tdi);
   endproperty
   a_id_shift: assert property (p_id_shift) // RQ8
      else $error("identification shift wrong");

   property p_busy_refuse;
      @(posedge tck) disable iff (tck_rst)
      tap_update_dr && sel inside {sel_dpa, sel_apa} && pending |=>
         c.req_tgl == $past(c.req_tgl);
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) // RQ5
      else $error("access launched while one is pending");
endmodule
`default_nettype wire

// >>> verif/tidc_tester.sv
`timescale 1ns/1ps
`default_nettype none
module tidc_tester (
   output var  logic tck,
   output var  logic por_n,
   output var  logic trst_n,
   output var  logic tap_tlr,
   output var  logic tap_capture_ir,
   output var  logic tap_shift_ir,
   output var  logic tap_update_ir,
   output var  logic tap_capture_dr,
   output var  logic tap_shift_dr,
   output var  logic tap_update_dr,
   output var  logic tdi,
   input  wire logic tdo
);
   logic o;
   initial tck = 1'b0;
   // Clock stands low between frames; tck-side syncs only move while a task clocks tck (scans, idle, reset)
   task automatic cyc(input logic [6:0] s, input logic d);
      {tap_tlr, tap_capture_ir, tap_shift_ir, tap_update_ir,
       tap_capture_dr, tap_shift_dr, tap_update_dr} = s;
      tdi = d;
      #6 tck = 1'b1;
      #6 tck = 1'b0;
      o = tdo;
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(7'h00, 1'b1);
   endtask
   // Kind 0 walks test-logic-reset, 1 pulses trst, 2 is power-on
   task automatic rst(input int k);
      por_n = (k != 2);
      trst_n = (k == 0);
      repeat (2) cyc((k == 0) ? 7'h40 : 7'h00, 1'b1);
      por_n = 1'b1;
      trst_n = 1'b1;
   endtask
   task automatic ir(input logic [3:0] c);
      cyc(7'h20, 1'b1);
      for (int i = 0; i < 4; i++) cyc(7'h10, c[i]);
      cyc(7'h08, 1'b1);
      idle(2);
   endtask
   task automatic dr(input int n, input logic [39:0] d,
                     output logic [39:0] q);
      q = 40'h0;
      cyc(7'h04, 1'b1);
      q[0] = o;
      for (int i = 0; i < n; i++) begin
         cyc(7'h02, d[i]);
         if (i < 39) q[i+1] = o;
      end
      cyc(7'h01, 1'b1);
      idle(4);
   endtask
endmodule
`default_nettype wire

// >>> verif/tidc_chains_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tidc_chains_tb_top;
   import tidc_pkg::*;
   localparam logic [31:0] ID = 32'h5E6D_2A11; // Arbitrary value
   localparam logic [31:0] RD = 32'hC0DE_4B7E;
   localparam logic [3:0]  CODE [6] = '{4'hE, 4'hF, 4'h8, 4'hA, 4'hB, 4'h2};
   localparam int          LEN [6] = '{32, 1, 35, 35, 35, 25};
   logic tck, por_n, trst_n, tdi, tdo, tdo_oe, dau_req, dau_abort;
   logic tap_tlr, tap_capture_ir, tap_shift_ir, tap_update_ir;
   logic tap_capture_dr, tap_shift_dr, tap_update_dr;
   logic        clk = 1'b0, rst_n = 1'b0, rst_pin = 1'b1, dau_done = 1'b0;
   logic [7:0]  pad_in = 8'h00, core_out = 8'h00, core_oe = 8'h00;
   logic [7:0]  pad_out, pad_oe, core_in, po, poe, ci;
   logic [2:0]  dau_ack;
   logic [31:0] dau_rdata;
   logic [34:0] dau_wdata, rw;
   logic [3:0]  dau_clr, rclr = 4'h0;
   logic [24:0] e;
   logic [39:0] q, w;
   tidc_kind_t  dau_kind, rk;
   int failures = 0, samples_checked = 0, nreq = 0, nab = 0, n0;
   int wt = 0, dly = 1, cycles = 0;

   tidc_tester tester (.*);
   tidc_chains #(.ID_VALUE(ID)) dut (.*);

   always #25 clk = ~clk;

   // Debug unit stand-in: notes each request, answers after dly clocks
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         end_sim();
      end
   end
   always @(posedge clk) begin
      if (dau_req) begin
         nreq++;
         rk = dau_kind;
         rw = dau_wdata;
      end
      if (dau_abort) nab++;
      if (dau_clr != 4'h0) rclr = dau_clr;
   end
   always @(negedge clk) begin
      dau_done <= !dau_req && wt == 1;
      if (dau_req) wt <= dly;
      else if (wt != 0) wt <= wt - 1;
   end

   task automatic chk(input logic [39:0] g, input logic [39:0] x);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task automatic end_sim();
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic t_ident();
      tester.dr(36, 40'hD, q);
      chk(q[31:0], ID);
      chk(q[0], 1'b1);
      tester.cyc(7'h04, 1'b1);
      chk(tdo_oe, 1'b1);
      tester.cyc(7'h01, 1'b1);
      tester.idle(1);
      chk(tdo_oe, 1'b0);
      chk((q >> 32) & 40'hF, 40'hD);
      $display("ident done");
   endtask

   task automatic t_reset();
      for (int k = 0; k < 3; k++) begin
         tester.ir(4'hF);
         tester.rst(k);
         tester.dr(32, 40'h0, q);
         chk(q[31:0], ID);
      end
      $display("reset done");
   endtask

   task automatic t_bypass();
      for (int c = 0; c < 16; c++)
         if (!(c inside {0, 1, 2, 8, 10, 11, 14})) begin
            tester.ir(4'(c));
            tester.dr(5, 40'hD, q);
            chk(q[0], 1'b0);
            chk((q >> 1) & 40'hF, 40'hD);
         end
      $display("bypass done");
   endtask

   task automatic t_len();
      for (int k = 0; k < 6; k++) begin
         tester.ir(CODE[k]);
         tester.dr(LEN[k] + 4, 40'hD, q);
         chk((q >> LEN[k]) & 40'hF, 40'hD);
      end
      $display("length done");
   endtask

   // Second pass answers slowly to stretch the cross-domain return
   task automatic t_access();
      for (int k = 0; k < 2; k++) begin
         dly = k ? 6 : 1;
         w = k ? 40'h5_9ABC_DEF0 : 40'h2_1357_9BDF;
         @(negedge clk);
         dau_ack = k ? 3'h4 : 3'h2;
         dau_rdata = k ? ~RD : RD;
         repeat (20) @(posedge clk);
         tester.ir(k ? 4'hB : 4'hA);
         n0 = nreq;
         tester.dr(35, w, q);
         for (int i = 0; i < 30 && nreq == n0; i++) @(posedge clk);
         chk(nreq, n0 + 1);
         chk(rw, w);
         chk(rk, k);
         for (int i = 0; i < 30 && !dau_done; i++) @(posedge clk);
         @(posedge clk);
         tester.idle(4);
         tester.dr(35, 40'h0, q);
         chk(q[34:0], {dau_rdata, dau_ack});
      end
      $display("access done");
   endtask

   task automatic t_abort();
      n0 = nab;
      tester.ir(4'h8);
      tester.dr(35, 40'hA8, q);
      for (int i = 0; i < 30 && nab == n0; i++) @(posedge clk);
      chk(nab, n0 + 1);
      chk(rclr, 4'hA);
      tester.dr(35, 40'h50, q);
      for (int i = 0; i < 30 && rclr == 4'hA; i++) @(posedge clk);
      chk(rclr, 4'h5);
      chk(nab, n0 + 1);
      $display("abort done");
   endtask

   task automatic t_boundary();
      @(negedge clk);
      pad_in = 8'h5A;
      core_out = 8'hC3;
      core_oe = 8'h0F;
      rst_pin = 1'b0;
      w = 40'h14B_6C3E;
      for (int i = 0; i < 8; i++) begin
         e[3*i +: 3] = {core_oe[i], core_out[i], pad_in[i]};
         po[i] = w[3*i+1];
         poe[i] = w[3*i+2];
         ci[i] = w[3*i];
      end
      e[24] = rst_pin;
      tester.ir(4'h2);
      chk(pad_out, core_out);
      chk(core_in, pad_in);
      tester.dr(25, w, q);
      chk(q[24:0], e);
      tester.ir(4'h0);
      chk(pad_out, po);
      chk(pad_oe, poe);
      tester.ir(4'h1);
      chk(core_in, ci);
      chk(pad_oe, core_oe);
      $display("boundary done");
   endtask

   initial begin
      tester.rst(2);
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_ident();
      t_reset();
      t_bypass();
      t_len();
      t_access();
      t_abort();
      t_boundary();
      end_sim();
   end
endmodule
`default_nettype wire
